//--- rtl/acr_pkg.sv
package acr_pkg;
    // Register addresses (6-bit map)
    localparam logic [5:0] ADDR_GAIN_HIGH = 6'h2f;
    localparam logic [5:0] ADDR_GAIN_LOW = 6'h30;
    localparam logic [5:0] ADDR_CHECKSUM = 6'h3e;
    localparam logic [5:0] ADDR_RESERVED = 6'h3f;
    // Reset values
    localparam logic [15:0] GAIN_HIGH_RESET = 16'h8000;
    localparam logic [7:0] GAIN_LOW_RESET = 8'h00;
    localparam logic [15:0] CHECKSUM_RESET = 16'h0000;
    localparam logic [15:0] RESERVED_RESET = 16'h0000;
    localparam logic [7:0] LOW_RESERVED_BYTE = 8'h00;
    // Serial word layout
    localparam int WORD_BITS = 16;
    localparam logic [3:0] LAST_BIT = 4'hf;
    localparam int CMD_WRITE_BIT = 15;
    localparam int CMD_ADDR_MSB = 13;
    localparam int CMD_ADDR_LSB = 8;
    // Checksum polynomial and seed
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    // Gain arithmetic: 24-bit coefficient, one integer bit
    localparam int SAMPLE_BITS = 24;
    localparam int GAIN_FRAC_BITS = 23;
    localparam logic signed [25:0] SAMPLE_MAX = 26'sh07fffff;
    localparam logic signed [25:0] SAMPLE_MIN = -26'sh0800000;
    typedef enum logic {PH_CMD, PH_DATA} acr_phase_type;
endpackage

//--- rtl/acr_regs.sv
`timescale 1ns/1ps
// Contract
// RQ1: Bits 15:8 of the channel-7 gain-trim low register hold gain bits 7:0 and are read/write.
// RQ2: The 24-bit gain is unsigned and scales results from zero to just under two.
// RQ3: The gain-trim high register holds gain bits 23:8 and resets to unity gain.
// RQ4: Bits 7:0 of the gain-trim low register ignore writes and read as zero.
// RQ5: A read-only 16-bit checksum at 0x3e resets to zero and reports the map CRC.
// RQ6: The host writes only zeros to the reserved register at 0x3f, which resets to zero.
// RQ7: The serial data output floats whenever chip select is high; here only once the synchronised select is high, two cycles later.
// RQ8: The host selects at most one device on a shared bus at a time.
// RQ9: For simultaneous sampling the host shares the master clock and strobes sync together.
// RQ10: The host may set per-device phase but tracks the zero-phase channel.
// RQ11: The host need watch only one device's ready output in a group.
// RQ12: The host wires sync or ready back to itself to stay aligned.
// RQ13: A host making the master clock may count its periods instead.
// RQ14: Without sync or ready, a clock bit error loses alignment for good.
// RQ15: With chip select tied low on a sole device the host should use both CRCs.
module acr_regs (
    input wire logic clk, // 125 MHz system clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic ce, // Clock enable, freezes all state when low
    input wire logic cs_n, // Serial chip select pin, active low
    input wire logic sclk, // Serial clock pin
    input wire logic mosi, // Serial data in pin
    output logic miso, // Serial data out
    output logic miso_oe, // Serial data out enable
    input wire logic signed [23:0] sample_in, // Raw channel-7 result
    input wire logic sample_valid, // Raw result strobe
    output logic signed [23:0] sample_out, // Gain-scaled result
    output logic sample_out_valid // Scaled result strobe
);
    logic cs_meta, cs_sync, sclk_meta, sclk_sync, sclk_prev, mosi_meta, mosi_sync;
    logic sclk_rise, sclk_fall;
    acr_pkg::acr_phase_type phase;
    logic [3:0] bit_index;
    logic [15:0] shift_in, next_shift_in, shift_out, write_data;
    logic [5:0] cmd_addr, next_addr;
    logic cmd_write, write_fire, refresh;
    logic [15:0] ch7_gain_coef_high_word, register_map_checksum, reserved_write_zero;
    logic [7:0] ch7_gain_coef_low_byte;
    logic [23:0] gain_coef;
    logic [15:0] crc_now;
    logic signed [48:0] product;
    logic signed [25:0] scaled;

    // Two-stage synchronisers on every pin input
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            sclk_meta <= 1'b0;
            sclk_sync <= 1'b0;
            sclk_prev <= 1'b0;
            mosi_meta <= 1'b0;
            mosi_sync <= 1'b0;
        end else if (ce) begin
            cs_meta <= cs_n;
            cs_sync <= cs_meta;
            sclk_meta <= sclk;
            sclk_sync <= sclk_meta;
            sclk_prev <= sclk_sync;
            mosi_meta <= mosi;
            mosi_sync <= mosi_meta;
        end
    end

    // Edges seen only from the settled stage
    assign sclk_rise = sclk_sync && !sclk_prev && !cs_sync;
    assign sclk_fall = !sclk_sync && sclk_prev && !cs_sync;
    assign next_shift_in = {shift_in[acr_pkg::WORD_BITS-2:0], mosi_sync};
    assign next_addr = next_shift_in[acr_pkg::CMD_ADDR_MSB:acr_pkg::CMD_ADDR_LSB];
    assign gain_coef = {ch7_gain_coef_high_word, ch7_gain_coef_low_byte};

    // Read mux; unmapped addresses return zero
    function automatic logic [15:0] read_word(input logic [5:0] addr,
                                              input logic [15:0] high,
                                              input logic [7:0] low,
                                              input logic [15:0] crc,
                                              input logic [15:0] rsvd);
        logic [15:0] word;
        word = 16'h0000;
        if (addr == acr_pkg::ADDR_GAIN_HIGH) begin
            word = high;
        end else if (addr == acr_pkg::ADDR_GAIN_LOW) begin
            // RQ4: low byte zero
            word = {low, acr_pkg::LOW_RESERVED_BYTE};
        end else if (addr == acr_pkg::ADDR_CHECKSUM) begin
            word = crc;
        end else if (addr == acr_pkg::ADDR_RESERVED) begin
            word = rsvd;
        end
        return word;
    endfunction

    // CRC-16 over the map contents, MSB first
    function automatic logic [15:0] map_crc(input logic [47:0] data);
        logic [15:0] crc;
        crc = acr_pkg::CRC_INIT;
        for (int i = 47; i >= 0; i--) begin
            if (crc[15] ^ data[i]) begin
                crc = {crc[14:0], 1'b0} ^ acr_pkg::CRC_POLY;
            end else begin
                crc = {crc[14:0], 1'b0};
            end
        end
        return crc;
    endfunction

    assign crc_now = map_crc({ch7_gain_coef_high_word, ch7_gain_coef_low_byte,
                              acr_pkg::LOW_RESERVED_BYTE, reserved_write_zero});

    // Frame sequencing: command word, then data word, repeating while selected
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            phase <= acr_pkg::PH_CMD;
            bit_index <= 4'h0;
            shift_in <= 16'h0000;
            cmd_addr <= 6'h00;
            cmd_write <= 1'b0;
            write_data <= 16'h0000;
            write_fire <= 1'b0;
        end else if (ce) begin
            write_fire <= 1'b0;
            if (cs_sync) begin
                phase <= acr_pkg::PH_CMD;
                bit_index <= 4'h0;
            end else if (sclk_fall) begin
                shift_in <= next_shift_in;
                bit_index <= bit_index + 4'h1;
                if (bit_index == acr_pkg::LAST_BIT) begin
                    if (phase == acr_pkg::PH_CMD) begin
                        cmd_addr <= next_addr;
                        cmd_write <= next_shift_in[acr_pkg::CMD_WRITE_BIT];
                        phase <= acr_pkg::PH_DATA;
                    end else begin
                        write_data <= next_shift_in;
                        write_fire <= cmd_write;
                        phase <= acr_pkg::PH_CMD;
                    end
                end
            end
        end
    end

    // Read data loads at end of command word, shifts out on rising edges
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            shift_out <= 16'h0000;
            miso <= 1'b0;
        end else if (ce) begin
            if (cs_sync) begin
                miso <= 1'b0;
            end else if (sclk_fall && bit_index == acr_pkg::LAST_BIT
                         && phase == acr_pkg::PH_CMD) begin
                shift_out <= read_word(next_addr, ch7_gain_coef_high_word,
                                       ch7_gain_coef_low_byte, register_map_checksum,
                                       reserved_write_zero);
            end else if (sclk_rise && phase == acr_pkg::PH_DATA) begin
                miso <= shift_out[acr_pkg::WORD_BITS-1];
                shift_out <= {shift_out[acr_pkg::WORD_BITS-2:0], 1'b0};
            end
        end
    end

    // RQ7: float when deselected
    // Follows the synchronised select, so release lags the pin by two cycles
    assign miso_oe = !cs_sync;

    // Writable registers; checksum address takes no write
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ch7_gain_coef_high_word <= acr_pkg::GAIN_HIGH_RESET;
            ch7_gain_coef_low_byte <= acr_pkg::GAIN_LOW_RESET;
            reserved_write_zero <= acr_pkg::RESERVED_RESET;
            refresh <= 1'b0;
        end else if (ce) begin
            refresh <= write_fire;
            if (write_fire) begin
                if (cmd_addr == acr_pkg::ADDR_GAIN_HIGH) begin
                    // RQ3: gain high word
                    ch7_gain_coef_high_word <= write_data;
                end else if (cmd_addr == acr_pkg::ADDR_GAIN_LOW) begin
                    // RQ1: gain low byte
                    ch7_gain_coef_low_byte <= write_data[15:8];
                end else if (cmd_addr == acr_pkg::ADDR_RESERVED) begin
                    // RQ6: stored as given, host keeps it zero
                    reserved_write_zero <= write_data;
                end
            end
        end
    end

    // RQ5: checksum refresh
    // Recomputed only after a write so the reset value stays zero until then
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            register_map_checksum <= acr_pkg::CHECKSUM_RESET;
        end else if (ce && refresh) begin
            register_map_checksum <= crc_now;
        end
    end

    // RQ2: unsigned gain scaling
    // Saturates since gains near two can overflow the 24-bit result
    assign product = $signed(sample_in) * $signed({1'b0, gain_coef});
    assign scaled = product[48:acr_pkg::GAIN_FRAC_BITS];
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sample_out <= 24'sh000000;
            sample_out_valid <= 1'b0;
        end else if (ce) begin
            sample_out_valid <= sample_valid;
            if (sample_valid) begin
                if (scaled > acr_pkg::SAMPLE_MAX) begin
                    sample_out <= acr_pkg::SAMPLE_MAX[acr_pkg::SAMPLE_BITS-1:0];
                end else if (scaled < acr_pkg::SAMPLE_MIN) begin
                    sample_out <= acr_pkg::SAMPLE_MIN[acr_pkg::SAMPLE_BITS-1:0];
                end else begin
                    sample_out <= scaled[acr_pkg::SAMPLE_BITS-1:0];
                end
            end
        end
    end

    a_gain_low_write: assert property (@(posedge clk) disable iff (!reset_n) // RQ1
        ce && write_fire && cmd_addr == acr_pkg::ADDR_GAIN_LOW
        |=> ch7_gain_coef_low_byte == $past(write_data[15:8]))
        else $error("gain low byte not written");
    a_unity_gain_pass: assert property (@(posedge clk) disable iff (!reset_n) // RQ2
        ce && sample_valid && gain_coef == 24'h800000
        |=> sample_out_valid && sample_out == $past(sample_in))
        else $error("unity gain altered the sample");
    a_gain_high_reset: assert property (@(posedge clk) // RQ3
        !reset_n |=> ch7_gain_coef_high_word == acr_pkg::GAIN_HIGH_RESET)
        else $error("gain high word reset wrong");
    a_low_byte_zero: assert property (@(posedge clk) disable iff (!reset_n) // RQ4
        ce && sclk_fall && bit_index == acr_pkg::LAST_BIT && phase == acr_pkg::PH_CMD
        && next_addr == acr_pkg::ADDR_GAIN_LOW |=> shift_out[7:0] == 8'h00)
        else $error("reserved low byte read non-zero");
    a_checksum_read_only: assert property (@(posedge clk) disable iff (!reset_n) // RQ5
        ce && write_fire && cmd_addr == acr_pkg::ADDR_CHECKSUM
        |=> register_map_checksum == $past(register_map_checksum))
        else $error("checksum changed by a write");
    a_checksum_follows_map: assert property (@(posedge clk) disable iff (!reset_n) // RQ5
        ce && refresh |=> register_map_checksum == $past(crc_now))
        else $error("checksum not refreshed");
    a_reserved_store: assert property (@(posedge clk) disable iff (!reset_n) // RQ6
        ce && write_fire && cmd_addr == acr_pkg::ADDR_RESERVED
        |=> reserved_write_zero == $past(write_data))
        else $error("reserved register not stored");
    a_output_floats: assert property (@(posedge clk) disable iff (!reset_n) // RQ7
        $past(cs_sync) && cs_sync && $past(ce) |-> !miso_oe && !miso)
        else $error("data out driven while deselected");
    a_float_after_pin: assert property (@(posedge clk) disable iff (!reset_n) // RQ7
        ce && cs_n ##1 ce && cs_n |=> !miso_oe || !ce)
        else $error("data out still driven after deselect");
    c_write_frame: cover property (@(posedge clk) ce && write_fire);
    c_read_gain_low: cover property (@(posedge clk)
        sclk_fall && phase == acr_pkg::PH_CMD && next_addr == acr_pkg::ADDR_GAIN_LOW);
    c_saturated: cover property (@(posedge clk) sample_valid && scaled > acr_pkg::SAMPLE_MAX);
endmodule

//--- verification/acr_host_model.sv
`timescale 1ns/1ps
module acr_host_model (
    input wire logic clk, // System clock, also the master clock
    input wire logic miso, // Serial data from device
    input wire logic miso_oe, // Device drive enable
    output logic cs_n, // Chip select, active low
    output logic sclk, // Serial clock, idles low
    output logic mosi, // Serial data to device
    output logic oe_ok // Enable seen at every bit
);
    // one select only
    // Sole device here, so a single select line and frames strictly one after another
    // shared clock
    // Master clock is clk itself; no sync strobe or ready pin exists on this block
    // host duties
    // No device group or phase trims; select toggles per frame, so no CRC mode needed
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
        oe_ok = 1'b1;
    end
    // One frame; five cycles per phase leaves margin over the three-cycle minimum
    task automatic frame(input logic wr, input logic [5:0] a, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [31:0] word;
        word = {wr, 1'b0, a, 8'h00, wd};
        @(negedge clk);
        cs_n = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 31; i >= 0; i--) begin
            mosi = word[i];
            sclk = 1'b1;
            repeat (5) @(negedge clk);
            if (i < 16) rd[i] = miso;
            oe_ok = oe_ok & miso_oe;
            sclk = 1'b0;
            repeat (5) @(negedge clk);
        end
        // Line no longer meaningful, so it stops showing the last bit
        mosi = ~mosi;
        cs_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask
endmodule

//--- verification/adc_cal_crc_regs_host_sync_test.sv
`timescale 1ns/1ps
module adc_cal_crc_regs_host_sync_test;
    localparam logic [5:0] MAP [5] = '{acr_pkg::ADDR_GAIN_HIGH, acr_pkg::ADDR_GAIN_LOW,
        acr_pkg::ADDR_CHECKSUM, acr_pkg::ADDR_RESERVED, 6'h31};
    logic clk, reset_n, ce, cs_n, sclk, mosi, miso, miso_oe, oe_ok;
    logic sample_valid, sample_out_valid;
    logic signed [23:0] sample_in, sample_out;
    logic [15:0] gain_high, rsvd, crc_v, rd, gh;
    logic [7:0] gain_low;
    int fails, n_tests;
    acr_regs dut_u (.clk(clk), .reset_n(reset_n), .ce(ce), .cs_n(cs_n), .sclk(sclk),
        .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .sample_in(sample_in),
        .sample_valid(sample_valid), .sample_out(sample_out),
        .sample_out_valid(sample_out_valid));
    acr_host_model host_u (.clk(clk), .miso(miso), .miso_oe(miso_oe), .cs_n(cs_n),
        .sclk(sclk), .mosi(mosi), .oe_ok(oe_ok));
    // Free-running 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Map checksum, MSB first over the modelled contents
    function automatic logic [15:0] crc_ref(input logic [47:0] m);
        logic [15:0] c;
        c = acr_pkg::CRC_INIT;
        for (int i = 47; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ m[i]) ? acr_pkg::CRC_POLY : 16'h0000);
        end
        return c;
    endfunction
    // Unsigned gain with one integer bit, clamped to the sample range
    function automatic logic [23:0] scale_ref(input logic signed [23:0] s, input logic [23:0] g);
        logic signed [48:0] p;
        p = (s * $signed({1'b0, g})) >>> 23;
        if (p > 49'sh07fffff) return 24'h7fffff;
        if (p < -49'sh0800000) return 24'h800000;
        return p[23:0];
    endfunction
    function automatic logic [15:0] exp_of(input logic [5:0] a);
        case (a)
            acr_pkg::ADDR_GAIN_HIGH: return gain_high;
            acr_pkg::ADDR_GAIN_LOW: return {gain_low, 8'h00};
            acr_pkg::ADDR_CHECKSUM: return crc_v;
            acr_pkg::ADDR_RESERVED: return rsvd;
            default: return 16'h0000;
        endcase
    endfunction
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Writes keep a shadow copy; any write refreshes the expected checksum
    task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
        host_u.frame(1'b1, a, d, rd);
        if (a == acr_pkg::ADDR_GAIN_HIGH) gain_high = d;
        if (a == acr_pkg::ADDR_GAIN_LOW) gain_low = d[15:8];
        if (a == acr_pkg::ADDR_RESERVED) rsvd = d;
        crc_v = crc_ref({gain_high, gain_low, 8'h00, rsvd});
    endtask
    // Read every mapped place plus one unmapped address
    task automatic check_map();
        for (int i = 0; i < 5; i++) begin
            host_u.frame(1'b0, MAP[i], 16'($urandom), rd);
            check("register read", exp_of(MAP[i]), rd);
        end
        check("idle enable", 1'b0, miso_oe);
        check("frame enable", 1'b1, oe_ok);
    endtask
    // Back-to-back strobes with both extremes first, to reach saturation
    task automatic run_samples(input int n);
        logic [23:0] s, exp_s;
        exp_s = 24'h000000;
        for (int i = 0; i < n; i++) begin
            s = (i == 0) ? 24'h7fffff : (i == 1) ? 24'h800000 : 24'($urandom);
            sample_in = s;
            sample_valid = 1'b1;
            @(negedge clk);
            exp_s = scale_ref(s, {gain_high, gain_low});
            check("scaled strobe", 1'b1, sample_out_valid);
            check("scaled value", exp_s, sample_out);
        end
        sample_valid = 1'b0;
        @(negedge clk);
        check("idle strobe", 1'b0, sample_out_valid);
        // Enable low must swallow a strobe and hold the last result
        ce = 1'b0;
        sample_valid = 1'b1;
        sample_in = 24'($urandom);
        @(negedge clk);
        check("frozen strobe", 1'b0, sample_out_valid);
        check("frozen value", exp_s, sample_out);
        ce = 1'b1;
        sample_valid = 1'b0;
        @(negedge clk);
    endtask
    task automatic end_of_test();
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Hang guard, well above the expected run length
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        end_of_test();
    end
    initial begin
        reset_n = 1'b0;
        ce = 1'b1;
        sample_in = 24'h000000;
        sample_valid = 1'b0;
        fails = 0;
        n_tests = 0;
        gain_high = acr_pkg::GAIN_HIGH_RESET;
        gain_low = 8'h00;
        rsvd = 16'h0000;
        crc_v = 16'h0000;
        void'($urandom(32'he316));
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        check_map();
        run_samples(4);
        // Extremes of the gain first, then random trims; junk to read-only places
        for (int r = 0; r < 4; r++) begin
            gh = (r == 0) ? 16'hffff : (r == 1) ? 16'h0000 : 16'($urandom);
            wr_reg(acr_pkg::ADDR_GAIN_HIGH, gh);
            wr_reg(acr_pkg::ADDR_GAIN_LOW, (r == 0) ? 16'hffff : 16'($urandom));
            host_u.frame(1'b1, acr_pkg::ADDR_CHECKSUM, 16'($urandom), rd);
            wr_reg(6'h31, 16'($urandom));
            wr_reg(acr_pkg::ADDR_RESERVED, 16'h0000);
            check_map();
            run_samples(12);
        end
        // Mid-run reset must restore unity gain and a zero checksum
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        gain_high = acr_pkg::GAIN_HIGH_RESET;
        gain_low = 8'h00;
        rsvd = 16'h0000;
        crc_v = 16'h0000;
        check("reset strobe", 1'b0, sample_out_valid);
        check("reset sample", 24'h000000, sample_out);
        check_map();
        run_samples(4);
        end_of_test();
    end
endmodule
